// *** rtl/dwc_top.sv ***
// Drive warning detection and alarm code output encoder
// ****************************************************************
// How it works
// - Position error over scaled level: code HHH
// - Same at servo on, motor powered: HHH
// - Overload pre-alarm warning: code LHH
// - Vibration reported as warning: LHH, else as alarm
// - Regenerative overload pre-alarm warning: HLH
// - Dynamic brake overload pre-alarm warning: HLH
// - Low encoder battery warning: LLH
// - Restart-needed parameter changed: HHL
// - Undervoltage pre-alarm warning: LLL
// - Overtravel while motor powered: HLL
// - Warning codes shown only when selection is 1
// - Disable setting 1 keeps only undervoltage
// - Phase low over 1 s trips alarm
// - Third phase low faults unless select is 1
// - Phase check also at main power-on
// - Encoder direction mismatch while motor powered flags load error
// ****************************************************************
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dwc_defs.svh"

module dwc_top
    import dwc_pkg::*;
#(
    parameter int ERR_W             = 32,
    parameter int OPEN_PHASE_CYCLES = `DWC_OPEN_PHASE_MS * 1000 * `DWC_CLK_MHZ
)
(
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [7:0]       avs_address_in,
    input  wire logic             avs_read_in,
    input  wire logic             avs_write_in,
    input  wire logic [31:0]      avs_writedata_in,
    input  wire logic [3:0]       avs_byteenable_in,
    output logic      [31:0]      avs_readdata_out,
    output logic                  avs_waitrequest_out,
    input  wire logic [ERR_W-1:0] pos_error_in,
    input  wire logic             motor_power_in,
    input  wire logic             overload_near_in,
    input  wire logic             vibration_in,
    input  wire logic             regen_near_in,
    input  wire logic             dbrake_near_in,
    input  wire logic             battery_low_in,
    input  wire logic             restart_param_in,
    input  wire logic             undervolt_near_in,
    input  wire logic             overtravel_in,
    input  wire logic             motor_dir_in,
    input  wire logic             ext_enc_dir_in,
    input  wire logic [2:0]       phase_low_in,
    input  wire logic             main_power_in,
    output logic                  code_out_bit_a_out,
    output logic                  code_out_bit_b_out,
    output logic                  code_out_bit_c_out,
    output logic                  code_valid_out,
    output logic                  vib_alarm_out,
    output logic                  load_err_alarm_out,
    output logic                  open_phase_alarm_out
);

    localparam int NW  = `DWC_NUM_WARN;
    localparam int PW  = 2 * ERR_W + 8;
    // Code table held as a constant so it can be part-selected
    localparam logic [3*NW-1:0] CODE_TABLE = `DWC_CODE_TABLE;

    if (ERR_W < 8 || ERR_W > 32)
    begin : g_chk
        $error("ERR_W must be 8..32");
    end

    // ****************************************************************
    // Registers and internal signals
    // ****************************************************************
    dwc_cfg_s          cfg_reg;
    logic [31:0]       err_lvl_reg;
    logic [31:0]       pct_reg;
    logic [31:0]       son_lvl_reg;
    logic              wait_reg;
    logic [31:0]       rdata_reg;
    logic [NW-1:0]     warn_reg;
    logic [NW-1:0]     warn_next;
    dwc_code_s         code_reg;
    dwc_code_s         code_next;
    logic              valid_reg;
    logic              valid_next;
    logic              vib_alarm_reg;
    logic              load_err_reg;
    logic              clr_open;
    logic              open_alarm;
    logic              wr_take;
    logic [31:0]       be_mask;
    logic [PW-1:0]     err_scaled;
    logic [PW-1:0]     lim_main;
    logic [PW-1:0]     lim_son;
    logic              vib_as_warn;
    logic              ext_dir;

    // ****************************************************************
    // Avalon slave: one wait cycle, then answer
    // ****************************************************************
    assign wr_take = avs_write_in && !wait_reg;
    assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

    // Waitrequest drops for one cycle per request
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            wait_reg <= 1'b1;
        else if ((avs_read_in || avs_write_in) && wait_reg)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    // Read data captured as waitrequest drops
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_reg <= 32'h0;
        else if (avs_read_in && wait_reg)
        begin
            unique case (avs_address_in)
                `DWC_OFS_CTRL:    rdata_reg <= cfg_reg;
                `DWC_OFS_ERR_LVL: rdata_reg <= err_lvl_reg;
                `DWC_OFS_PCT:     rdata_reg <= pct_reg;
                `DWC_OFS_SON_LVL: rdata_reg <= son_lvl_reg;
                `DWC_OFS_STATUS:
                begin
                    rdata_reg                                   <= 32'(warn_reg);
                    rdata_reg[`DWC_STAT_OPEN_BIT]               <= open_alarm;
                    rdata_reg[`DWC_STAT_VIB_BIT]                <= vib_alarm_reg;
                    rdata_reg[`DWC_STAT_LOAD_BIT]               <= load_err_reg;
                    rdata_reg[`DWC_STAT_CODE_LSB+:3]            <= code_reg;
                    rdata_reg[`DWC_STAT_VALID_BIT]              <= valid_reg;
                end
                default:          rdata_reg <= 32'h0;
            endcase
        end
    end

    // Settings writes, honouring byte enables
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cfg_reg     <= `DWC_RST_CTRL;
            err_lvl_reg <= `DWC_RST_LVL;
            pct_reg     <= `DWC_RST_PCT;
            son_lvl_reg <= `DWC_RST_LVL;
        end
        else if (wr_take)
        begin
            unique case (avs_address_in)
                `DWC_OFS_CTRL:
                    cfg_reg <= (cfg_reg & ~be_mask) | (avs_writedata_in & be_mask);
                `DWC_OFS_ERR_LVL:
                    err_lvl_reg <= (err_lvl_reg & ~be_mask) | (avs_writedata_in & be_mask);
                `DWC_OFS_PCT:
                    pct_reg <= (pct_reg & ~be_mask) | (avs_writedata_in & be_mask);
                `DWC_OFS_SON_LVL:
                    son_lvl_reg <= (son_lvl_reg & ~be_mask) | (avs_writedata_in & be_mask);
                default: ;
            endcase
        end
    end

    // Clear strobe for the open-phase alarm
    assign clr_open = wr_take && avs_address_in == `DWC_OFS_CLEAR
                      && avs_byteenable_in[0] && avs_writedata_in[`DWC_CLR_OPEN_BIT];

    // ****************************************************************
    // Warning detection
    // ****************************************************************
    // Compare error*100 against level*percent, no divider needed
    assign err_scaled  = PW'(pos_error_in) * PW'(`DWC_PCT_DIV);
    assign lim_main    = PW'(err_lvl_reg[ERR_W-1:0]) * PW'(pct_reg[15:0]);
    assign lim_son     = PW'(son_lvl_reg[ERR_W-1:0]) * PW'(pct_reg[31:16]);
    assign vib_as_warn = cfg_reg.vibration_report_select == `DWC_SEL_ON;

    // Raw warning set, index order follows warning number
    always_comb
    begin
        warn_next    = '0;
        warn_next[0] = err_scaled > lim_main;
        warn_next[1] = motor_power_in && err_scaled > lim_son;
        warn_next[2] = overload_near_in;
        warn_next[3] = vibration_in && vib_as_warn;
        warn_next[4] = regen_near_in;
        warn_next[5] = dbrake_near_in;
        warn_next[6] = battery_low_in;
        warn_next[7] = restart_param_in;
        warn_next[8] = undervolt_near_in;
        warn_next[9] = overtravel_in && motor_power_in;
        if (cfg_reg.warning_detect_disable == `DWC_SEL_ON)
            warn_next = warn_next & (NW'(1) << `DWC_IDX_UNDERVOLT);
    end

    // Active warning set
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            warn_reg <= '0;
        else
            warn_reg <= warn_next;
    end

    // Vibration reported as an alarm when not a warning
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            vib_alarm_reg <= 1'b0;
        else
            vib_alarm_reg <= vibration_in && !vib_as_warn;
    end

    // Motor and external encoder directions must agree
    assign ext_dir = ext_enc_dir_in ^ (cfg_reg.ext_encoder_usage == `DWC_EXT_REVERSE);

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            load_err_reg <= 1'b0;
        else
            load_err_reg <= motor_power_in && (motor_dir_in != ext_dir);
    end

    // ****************************************************************
    // Code selection and output
    // ****************************************************************
    // Lowest active index wins; gated by the output setting
    always_comb
    begin
        code_next  = `DWC_CODE_IDLE;
        valid_next = 1'b0;
        for (int i = NW - 1; i >= 0; i--)
        begin
            if (warn_reg[i])
            begin
                code_next  = CODE_TABLE[3*(NW-1-i)+:3];
                valid_next = 1'b1;
            end
        end
        if (cfg_reg.code_output_select != `DWC_SEL_ON)
        begin
            code_next  = `DWC_CODE_IDLE;
            valid_next = 1'b0;
        end
    end

    // All three pins change on the same edge
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            code_reg  <= `DWC_CODE_IDLE;
            valid_reg <= 1'b0;
        end
        else
        begin
            code_reg  <= code_next;
            valid_reg <= valid_next;
        end
    end

    // ****************************************************************
    // Open-phase monitor
    // ****************************************************************
    dwc_phase_mon #(
        .OPEN_PHASE_CYCLES (OPEN_PHASE_CYCLES)
    ) u_phase (
        .clk_in          (clk_in),
        .arst_n_in       (arst_n_in),
        .phase_low_in    (phase_low_in),
        .main_power_in   (main_power_in),
        .single_phase_in (cfg_reg.supply_phase_select == `DWC_SEL_ON),
        .clear_in        (clr_open),
        .alarm_out       (open_alarm)
    );

    // Outputs straight from flip-flops
    assign avs_readdata_out     = rdata_reg;
    assign avs_waitrequest_out  = wait_reg;
    assign code_out_bit_a_out   = code_reg.bit_a;
    assign code_out_bit_b_out   = code_reg.bit_b;
    assign code_out_bit_c_out   = code_reg.bit_c;
    assign code_valid_out       = valid_reg;
    assign vib_alarm_out        = vib_alarm_reg;
    assign load_err_alarm_out   = load_err_reg;
    assign open_phase_alarm_out = open_alarm;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_pos_err_code: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (err_scaled > lim_main && cfg_reg.code_output_select == `DWC_SEL_ON
         && cfg_reg.warning_detect_disable != `DWC_SEL_ON)
        ##1 $stable(cfg_reg) |=> code_reg == 3'b111 && valid_reg)
        else $error("position error warning not coded HHH");

    a_son_needs_power: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        !motor_power_in && !(err_scaled > lim_main) |=> !warn_reg[1])
        else $error("servo-on warning without motor power");

    a_overtravel_code: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        warn_reg == 10'h200 && cfg_reg.code_output_select == `DWC_SEL_ON
        |=> code_reg == 3'b100)
        else $error("overtravel code not HLL");

    a_undervolt_code: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        warn_reg[8:0] == 9'h100 && cfg_reg.code_output_select == `DWC_SEL_ON
        |=> code_reg == 3'b000 && valid_reg)
        else $error("undervoltage code not LLL");

    a_gate_output: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        cfg_reg.code_output_select != `DWC_SEL_ON |=> !valid_reg
        && code_reg == `DWC_CODE_IDLE)
        else $error("warning code shown while output disabled");

    a_disable_mask: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        cfg_reg.warning_detect_disable == `DWC_SEL_ON
        |=> warn_reg[7:0] == 8'h0 && warn_reg[9] == 1'b0 && warn_reg[8] == $past(undervolt_near_in))
        else $error("warning detected while detection disabled");

    a_battery_code: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        warn_reg == 10'h040 && cfg_reg.code_output_select == `DWC_SEL_ON
        |=> code_reg == 3'b001)
        else $error("battery code not LLH");

    a_idle_when_none: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        warn_reg == '0 |=> !valid_reg && code_reg == `DWC_CODE_IDLE)
        else $error("code not idle with no warning");

    a_vib_one_path: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        vibration_in ##1 1'b1 |-> (vib_alarm_reg != warn_reg[3])
        || cfg_reg.warning_detect_disable == `DWC_SEL_ON || $changed(cfg_reg))
        else $error("vibration not reported on exactly one path");

    a_load_dir: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        motor_power_in && motor_dir_in == ext_enc_dir_in
        && cfg_reg.ext_encoder_usage != `DWC_EXT_REVERSE |=> !load_err_reg)
        else $error("load error raised with matching directions");

    a_wait_answer: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (avs_read_in || avs_write_in) && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("waitrequest did not drop for exactly one cycle");

endmodule : dwc_top
`default_nettype wire

// *** rtl/dwc_defs.svh ***
// Constants for the drive warning code encoder
`ifndef DWC_DEFS_SVH
`define DWC_DEFS_SVH

// ****************************************************************
// Sizes and timing
// ****************************************************************
`define DWC_NUM_WARN        10
`define DWC_PCT_DIV         100
`define DWC_CLK_MHZ         100
`define DWC_OPEN_PHASE_MS   1000
`define DWC_NUM_PHASE       3

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DWC_OFS_CTRL        8'h00
`define DWC_OFS_ERR_LVL     8'h04
`define DWC_OFS_PCT         8'h08
`define DWC_OFS_SON_LVL     8'h0C
`define DWC_OFS_STATUS      8'h10
`define DWC_OFS_CLEAR       8'h14

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DWC_STAT_OPEN_BIT   16
`define DWC_STAT_VIB_BIT    17
`define DWC_STAT_LOAD_BIT   18
`define DWC_STAT_CODE_LSB   20
`define DWC_STAT_VALID_BIT  23
`define DWC_CLR_OPEN_BIT    0
`define DWC_RST_CTRL        32'h0000_0000
`define DWC_RST_LVL         32'h0000_FFFF
`define DWC_RST_PCT         32'h0064_0064

// ****************************************************************
// Setting values and codes (order a, b, c)
// ****************************************************************
`define DWC_SEL_ON          4'h1
`define DWC_EXT_REVERSE     4'h1
`define DWC_CODE_IDLE       3'h0
`define DWC_IDX_UNDERVOLT   8
`define DWC_CODE_TABLE      30'b111_111_011_011_101_101_001_110_000_100

`endif

// *** rtl/dwc_pkg.sv ***
// Types shared by the drive warning code encoder
package dwc_pkg;

    // Settings word held in the control register
    typedef struct packed {
        logic [11:0] spare;
        logic [3:0]  vibration_report_select;
        logic [3:0]  ext_encoder_usage;
        logic [3:0]  supply_phase_select;
        logic [3:0]  warning_detect_disable;
        logic [3:0]  code_output_select;
    } dwc_cfg_s;

    // Three code pins travelling together
    typedef struct packed {
        logic bit_a;
        logic bit_b;
        logic bit_c;
    } dwc_code_s;

    // Open-phase monitor states, Gray along the path
    typedef enum logic [1:0] {
        DWC_MON_OFF  = 2'b00,
        DWC_MON_RUN  = 2'b01,
        DWC_MON_TRIP = 2'b11
    } dwc_mon_e;

endpackage : dwc_pkg

// *** rtl/dwc_phase_mon.sv ***
// Main circuit open-phase monitor
`timescale 1ns/1ps
`default_nettype none
`include "dwc_defs.svh"

module dwc_phase_mon
    import dwc_pkg::*;
#(
    parameter int OPEN_PHASE_CYCLES = `DWC_OPEN_PHASE_MS * 1000 * `DWC_CLK_MHZ
)
(
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic [2:0] phase_low_in,
    input  wire logic       main_power_in,
    input  wire logic       single_phase_in,
    input  wire logic       clear_in,
    output logic            alarm_out
);

    if (OPEN_PHASE_CYCLES < 2 || OPEN_PHASE_CYCLES > 32'h7FFF_FFFF)
    begin : g_chk
        $error("OPEN_PHASE_CYCLES out of range");
    end

    logic [2:0]  ph_s1_reg;
    logic [2:0]  ph_s2_reg;
    logic        pwr_s1_reg;
    logic        pwr_s2_reg;
    logic [31:0] cnt_reg;
    dwc_mon_e    state_reg;
    logic        any_low;

    // ****************************************************************
    // Two-stage synchronisers, one per phase pin
    // ****************************************************************
    for (genvar i = 0; i < `DWC_NUM_PHASE; i++)
    begin : g_sync
        always_ff @(posedge clk_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
            begin
                ph_s1_reg[i] <= 1'b0;
                ph_s2_reg[i] <= 1'b0;
            end
            else
            begin
                ph_s1_reg[i] <= phase_low_in[i];
                ph_s2_reg[i] <= ph_s1_reg[i];
            end
        end
    end

    // Power pin synchroniser
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pwr_s1_reg <= 1'b0;
            pwr_s2_reg <= 1'b0;
        end
        else
        begin
            pwr_s1_reg <= main_power_in;
            pwr_s2_reg <= pwr_s1_reg;
        end
    end

    // Single-phase setting ignores the third phase
    assign any_low = ph_s2_reg[0] | ph_s2_reg[1] | (ph_s2_reg[2] & ~single_phase_in);

    // ****************************************************************
    // Monitor: check at power-on, then time low phases
    // ****************************************************************
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg <= DWC_MON_OFF;
            cnt_reg   <= 32'h0;
        end
        else
        begin
            unique case (state_reg)
                DWC_MON_OFF:
                begin
                    cnt_reg <= 32'h0;
                    if (pwr_s2_reg && any_low)
                        state_reg <= DWC_MON_TRIP;
                    else if (pwr_s2_reg)
                        state_reg <= DWC_MON_RUN;
                end
                DWC_MON_RUN:
                begin
                    cnt_reg <= any_low ? cnt_reg + 32'h1 : 32'h0;
                    if (!pwr_s2_reg)
                        state_reg <= DWC_MON_OFF;
                    else if (any_low && cnt_reg >= 32'(OPEN_PHASE_CYCLES))
                        state_reg <= DWC_MON_TRIP;
                end
                DWC_MON_TRIP:
                begin
                    cnt_reg <= 32'h0;
                    if (!pwr_s2_reg)
                        state_reg <= DWC_MON_OFF;
                end
                default:
                    state_reg <= DWC_MON_OFF;
            endcase
        end
    end

    // Sticky alarm; a new trip wins over a clear
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            alarm_out <= 1'b0;
        else if (state_reg == DWC_MON_TRIP)
            alarm_out <= 1'b1;
        else if (clear_in)
            alarm_out <= 1'b0;
    end

    a_trip_sets_alarm: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        state_reg == DWC_MON_TRIP |=> alarm_out)
        else $error("open-phase trip did not raise alarm");

endmodule : dwc_phase_mon
`default_nettype wire

// *** dv/dwc_host_model.sv ***
// Host controller model that latches the alarm code pins
`timescale 1ns/1ps
`default_nettype none
module dwc_host_model
    import dwc_pkg::*;
(
    input  wire logic      clk_in,
    input  wire dwc_code_s code_in,
    input  wire logic      valid_in,
    output logic [3:0]     seen_out
);
    // Take all pins on one edge, as a host would
    always_ff @(posedge clk_in)
    begin
        seen_out <= {valid_in, code_in};
    end
endmodule : dwc_host_model
`default_nettype wire

// *** dv/drive_warning_code_encoder_bench.sv ***
// Self-checking bench for the warning code encoder
`timescale 1ns/1ps
`default_nettype none
module drive_warning_code_encoder_bench
    import dwc_pkg::*;
;
    logic        clk_in = 0, arst_n_in = 0, rd = 0, wr = 0, mp = 0, md = 0, ed = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, pe = 32'h0, q, rdat;
    logic [8:0]  lv = 9'h000;
    logic [2:0]  ph = 3'h0;
    logic [3:0]  seen;
    logic        wt, v, vib, lde, opa;
    dwc_code_s   code;
    int          n_mismatch = 0, samples_checked = 0, k;
    // Rows: error, {power,ovl,vib,regen,db,batt,restart,uv,ot}, {valid,a,b,c}
    logic [44:0] rows [14] = '{
        {32'h1_0000, 9'h000, 4'hF}, {32'h0_FFFF, 9'h000, 4'h0},
        {32'h1_0000, 9'h100, 4'hF}, {32'h0, 9'h080, 4'hB},
        {32'h0, 9'h040, 4'hB}, {32'h0, 9'h020, 4'hD},
        {32'h0, 9'h010, 4'hD}, {32'h0, 9'h008, 4'h9},
        {32'h0, 9'h004, 4'hE}, {32'h0, 9'h002, 4'h8},
        {32'h0, 9'h101, 4'hC}, {32'h0, 9'h001, 4'h0},
        {32'h0, 9'h0A4, 4'hB}, {32'h0, 9'h00E, 4'h9}};

    // Clock
    always #5 clk_in = ~clk_in;

    dwc_top #(.OPEN_PHASE_CYCLES(20)) u_dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
        .pos_error_in(pe), .motor_power_in(lv[8]), .overload_near_in(lv[7]),
        .vibration_in(lv[6]), .regen_near_in(lv[5]), .dbrake_near_in(lv[4]),
        .battery_low_in(lv[3]), .restart_param_in(lv[2]), .undervolt_near_in(lv[1]),
        .overtravel_in(lv[0]), .motor_dir_in(md), .ext_enc_dir_in(ed),
        .phase_low_in(ph), .main_power_in(mp), .code_out_bit_a_out(code.bit_a),
        .code_out_bit_b_out(code.bit_b), .code_out_bit_c_out(code.bit_c),
        .code_valid_out(v), .vib_alarm_out(vib), .load_err_alarm_out(lde),
        .open_phase_alarm_out(opa));

    dwc_host_model u_host (.clk_in(clk_in), .code_in(code), .valid_in(v), .seen_out(seen));

    // Verdict and end of run
    task end_sim;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // Compare and count
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk

    // One Avalon transfer, held until waitrequest is low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        @(posedge clk_in);
        for (k = 0; wt !== 1'b0; k++)
        begin
            if (k == 9)
            begin
                n_mismatch++;
                end_sim;
            end
            @(posedge clk_in);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_in);
    endtask : bus

    // Let pins settle, then compare {valid,a,b,c,vib,load,open}
    task look(input logic [6:0] e);
        repeat (3) @(posedge clk_in);
        #1 chk({seen, vib, lde, opa}, e);
        @(posedge clk_in);
    endtask : look

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_in);
        arst_n_in <= 1'b1;
        #1 chk({wt, v, code, vib, lde, opa}, 8'h80);
        @(posedge clk_in);
        bus(1'b0, 8'h08, 32'h0);
        chk(q, 32'h0064_0064);
        bus(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0000_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 8'h00, 32'h0001_0001);
        for (int i = 0; i < 14; i++)
        begin
            {pe, lv} <= rows[i][44:4];
            look({rows[i][3:0], 3'h0});
        end
        bus(1'b1, 8'h00, 32'h0001_0000);
        lv <= 9'h008;
        look(7'h00);
        bus(1'b1, 8'h00, 32'h0001_0011);
        lv <= 9'h04A;
        look(7'h40);
        bus(1'b1, 8'h00, 32'h0000_0001);
        lv <= 9'h040;
        look(7'h04);
        lv <= 9'h100;
        md <= 1'b1;
        look(7'h02);
        bus(1'b1, 8'h00, 32'h0000_1001);
        look(7'h00);
        bus(1'b1, 8'h00, 32'h0000_0001);
        lv <= 9'h000;
        md <= 1'b0;
        mp <= 1'b1;
        look(7'h00);
        ph <= 3'h1;
        repeat (12) @(posedge clk_in);
        look(7'h00);
        for (k = 0; k < 40 && opa !== 1'b1; k++) @(posedge clk_in);
        #1 chk(opa, 1'b1);
        @(posedge clk_in);
        ph <= 3'h2;
        mp <= 1'b0;
        // Power-off must reach the monitor first, a pending trip beats the clear
        repeat (4) @(posedge clk_in);
        bus(1'b1, 8'h14, 32'h1);
        look(7'h00);
        mp <= 1'b1;
        for (k = 0; k < 10 && opa !== 1'b1; k++) @(posedge clk_in);
        #1 chk(opa, 1'b1);
        @(posedge clk_in);
        ph <= 3'h4;
        mp <= 1'b0;
        bus(1'b1, 8'h00, 32'h0000_0101);
        bus(1'b1, 8'h14, 32'h1);
        mp <= 1'b1;
        repeat (40) @(posedge clk_in);
        look(7'h00);
        end_sim;
    end
endmodule : drive_warning_code_encoder_bench
`default_nettype wire
